// ### core/ntms_master.sv
/*
  Holds the top of the network time master block: arbitration of the broadcast role,
  the periodic status broadcast, the following of other masters, the handling of set
  commands and their acknowledge, and the local calendar and tick below it.
  Assumes that a frame engine on the same clock presents each received frame as a
  one-cycle pulse with its group number, source address and eight payload bytes, and
  that it takes an outgoing status frame on a valid and ready handshake.
*/
// Summary of operation
// - Wait three seconds after joining before broadcasting.
// - Stop broadcasting when higher source address broadcasts.
// - Resume after three seconds without the message.
// - Load clock from another node's status message.
// - Highest priority clock is official; others follow.
// - Master broadcasts every 1000 ms, never faster.
// - Byte zero: year above 2000, up to 2250.
// - Byte one: month, 1 January to 12.
// - Byte two: day of month, 1 to 31.
// - Byte three: weekday, 1 Sunday to 7.
// - Byte four: local hour 0 to 23.
// - Bytes five, six: minute and second, 0-59.
// - Byte seven: time zone hour offset code.
// - Set request loads the clock with given time.
// - Set request uses the status message layout.
// - All bytes 255 except hour, zone: zone change.
// - Always acknowledge set; answer status only as master.
`timescale 1ns/1ps
module ntms_master #(
  parameter logic [27:0] TICK_CYCLES = 28'(ntms_pkg::TICK_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Own identity on the network
  input wire logic [7:0] own_addr,
  // Received frames, one-cycle pulse per frame
  input wire logic rx_valid,
  input wire logic [16:0] rx_data_group_number,
  input wire logic [7:0] rx_src,
  input wire logic [63:0] rx_data,
  // Outgoing status frame, held until taken
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [63:0] tx_data,
  // Acknowledge of a set command, one-cycle pulse
  output logic ack_valid,
  output logic [7:0] ack_dest,
  // Role and current time
  output logic is_master,
  output logic [63:0] time_now
);
  ////////////////////////////////////////////////////////////////////////////////////////
  // State and helper functions.
  ////////////////////////////////////////////////////////////////////////////////////////

  // All control state of the block in one record.
  typedef struct packed {
    ntms_pkg::ntms_state_t fsm; // Arbitration state.
    logic [1:0] hold_cnt; // Seconds spent in hold-off.
    logic [1:0] sil_cnt; // Seconds without a status message from others.
    logic [1:0] per_cnt; // Seconds since the last periodic broadcast.
    logic resp_pend; // A status answer to a set command is owed.
    logic tx_valid; // Outgoing frame is offered.
    logic [63:0] tx_data; // Payload of the offered frame.
    logic ack_valid; // Acknowledge pulse.
    logic [7:0] ack_dest; // Sender of the acknowledged command.
    logic is_master; // Role flag shown outside.
    logic load_all; // Full calendar load pulse.
    logic load_tz; // Hour and zone load pulse.
    logic [63:0] load_data; // Data that goes with either load.
  } ntms_ctl_t;

  ntms_ctl_t st_r; // Registered state.
  ntms_ctl_t st_nxt; // Next state.
  logic tick; // One-second pulse.
  logic [63:0] cal_now; // Calendar in payload layout.
  logic rx_status; // A status frame from another node arrived.
  logic rx_set; // A set command from another node arrived.
  logic launch; // A frame is offered in this cycle.

  // Tells whether a received frame carries the given group and is not our own echo.
  function automatic logic frame_is(input logic vld, input logic [16:0] grp,
                                    input logic [7:0] src, input logic [7:0] own,
                                    input logic [16:0] want);
    frame_is = vld && grp == want && src != own;
  endfunction

  // Tells whether a set payload is a time-zone change: every byte but hour and zone is fill.
  function automatic logic zone_only(input logic [63:0] d);
    zone_only = 1'b1;
    for (int i = 0; i < ntms_pkg::PAYLOAD_BYTES; i++) begin
      if (i != ntms_pkg::BYTE_HOUR && i != ntms_pkg::BYTE_ZONE && d[8*i +: 8] != ntms_pkg::FILL_BYTE) begin
        zone_only = 1'b0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // Tick and calendar.
  ////////////////////////////////////////////////////////////////////////////////////////

  // The single tick paces the calendar, the hold-off, the silence and the period.
  ntms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .tick(tick)
  );

  // The calendar takes loads two edges after the frame that caused them, as the load pulses are registered first.
  ntms_cal u_cal (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .load_all(st_r.load_all),
    .load_tz(st_r.load_tz),
    .load_data(st_r.load_data),
    .now(cal_now)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // Frame classification.
  ////////////////////////////////////////////////////////////////////////////////////////

  // Frames that we sent ourselves are never taken as another node's message.
  assign rx_status = frame_is(rx_valid, rx_data_group_number, rx_src, own_addr,
                              ntms_pkg::GRP_STATUS);
  assign rx_set = frame_is(rx_valid, rx_data_group_number, rx_src, own_addr,
                           ntms_pkg::GRP_SET);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////////////////////

  // Arbitrates the role, times the broadcast and reacts to received frames.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_valid = 1'b0;
    st_nxt.load_all = 1'b0;
    st_nxt.load_tz = 1'b0;
    launch = 1'b0;

    // The role machine.
    unique case (st_r.fsm)
      ntms_pkg::ST_HOLD: begin
        // Counts out the hold-off before the first broadcast.
        if (tick) begin
          st_nxt.hold_cnt = st_r.hold_cnt + 2'b01;
          if (st_r.hold_cnt + 2'b01 >= ntms_pkg::HOLD_TICKS) begin
            st_nxt.fsm = ntms_pkg::ST_MASTER;
            st_nxt.per_cnt = ntms_pkg::PERIOD_TICKS - 2'b01;
          end
        end
      end
      ntms_pkg::ST_MASTER: begin
        // Stays master until a higher address is heard.
        st_nxt.fsm = ntms_pkg::ST_MASTER;
      end
      ntms_pkg::ST_FOLLOW: begin
        // Counts silent seconds and takes the role back after enough of them.
        if (tick) begin
          st_nxt.sil_cnt = st_r.sil_cnt + 2'b01;
          if (st_r.sil_cnt + 2'b01 >= ntms_pkg::SILENCE_TICKS) begin
            st_nxt.fsm = ntms_pkg::ST_MASTER;
            st_nxt.per_cnt = ntms_pkg::PERIOD_TICKS - 2'b01;
          end
        end
      end
      default: begin
        // An illegal code falls back to a fresh hold-off.
        st_nxt.fsm = ntms_pkg::ST_HOLD;
        st_nxt.hold_cnt = '0;
      end
    endcase

    // Another node's status message: follow it, and yield to a higher address.
    if (rx_status) begin
      st_nxt.sil_cnt = '0;
      st_nxt.load_all = 1'b1;
      st_nxt.load_data = rx_data;
      if (rx_src > own_addr) begin
        st_nxt.fsm = ntms_pkg::ST_FOLLOW;
        st_nxt.resp_pend = 1'b0;
      end
    end

    // A set command is always acknowledged; only a master owes a status answer.
    if (rx_set) begin
      st_nxt.ack_valid = 1'b1;
      st_nxt.ack_dest = rx_src;
      st_nxt.load_data = rx_data;
      if (zone_only(rx_data)) begin
        st_nxt.load_tz = 1'b1;
      end else begin
        st_nxt.load_all = 1'b1;
      end
      if (st_r.fsm == ntms_pkg::ST_MASTER && !rx_status) begin
        st_nxt.resp_pend = 1'b1;
      end
    end

    // The period counter runs only for a master and fires once per period.
    if (st_nxt.fsm == ntms_pkg::ST_MASTER && tick) begin
      if (st_r.per_cnt + 2'b01 >= ntms_pkg::PERIOD_TICKS) begin
        st_nxt.per_cnt = '0;
        launch = 1'b1;
      end else begin
        st_nxt.per_cnt = st_r.per_cnt + 2'b01;
      end
    end
    if (st_r.resp_pend && st_nxt.fsm == ntms_pkg::ST_MASTER) begin
      launch = 1'b1;
    end

    // Retires a frame that the engine took.
    if (st_r.tx_valid && tx_ready) begin
      st_nxt.tx_valid = 1'b0;
    end

    // A frame is offered only when none is pending; a missed period is skipped,
    // so periodic broadcasts never come closer than the period; an owed answer goes out without waiting for it.
    if (launch && !st_r.tx_valid) begin
      st_nxt.tx_valid = 1'b1;
      st_nxt.tx_data = cal_now;
      st_nxt.resp_pend = 1'b0;
    end

    // The role flag follows the machine.
    st_nxt.is_master = st_nxt.fsm == ntms_pkg::ST_MASTER;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // State register.
  ////////////////////////////////////////////////////////////////////////////////////////

  // Reset drops the role and restarts the hold-off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{fsm: ntms_pkg::ST_HOLD, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register, except time_now, which comes from the calendar.
  assign tx_valid = st_r.tx_valid;
  assign tx_data = st_r.tx_data;
  assign ack_valid = st_r.ack_valid;
  assign ack_dest = st_r.ack_dest;
  assign is_master = st_r.is_master;
  assign time_now = cal_now;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Only a master offers a frame.
  a_tx_only_master: assert property (
    $rose(tx_valid) |-> is_master) else $error("frame offered without mastership");
  // A higher address takes the role away on the next edge.
  a_yield_higher: assert property (
    rx_status && rx_src > own_addr |=> !is_master && st_r.fsm == ntms_pkg::ST_FOLLOW)
    else $error("did not yield to higher address");
  // A follower that hears nothing for the last silent second becomes master.
  a_resume_silence: assert property (
    st_r.fsm == ntms_pkg::ST_FOLLOW && st_r.sil_cnt == ntms_pkg::SILENCE_TICKS - 2'b01
    && tick && !rx_status |=> is_master) else $error("did not resume after silence");
  // A status from another node reaches the calendar two edges later.
  a_follow_status: assert property (
    rx_status |=> st_r.load_all ##1 time_now == $past(rx_data, 2))
    else $error("status not loaded into clock");
  // A follower never holds the role.
  a_follower_quiet: assert property (
    st_r.fsm != ntms_pkg::ST_MASTER |-> !is_master) else $error("role flag wrong");
  // A new frame starts only on a tick or for an owed answer.
  a_tx_cause: assert property (
    $rose(tx_valid) |-> $past(tick) || $past(st_r.resp_pend))
    else $error("frame offered without cause");
  // An offered frame stands until taken.
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("frame dropped");
  // Every set command is acknowledged to its sender.
  a_set_ack: assert property (
    rx_set |=> ack_valid && ack_dest == $past(rx_src)) else $error("set not acknowledged");
  // A follower owes no answer to a set command.
  a_no_answer: assert property (
    rx_set && st_r.fsm != ntms_pkg::ST_MASTER && !st_r.resp_pend |=> !st_r.resp_pend)
    else $error("follower answered a set");
  // A zone-only command changes just hour and zone.
  a_zone_only: assert property (
    rx_set && zone_only(rx_data) |=> st_r.load_tz && !st_r.load_all)
    else $error("zone change mishandled");

  // Main scenarios: taking the role, yielding, a zone change, and an answer to a set command.
  c_hold_to_master: cover property (st_r.fsm == ntms_pkg::ST_HOLD ##1 is_master);
  c_yield: cover property (is_master ##1 st_r.fsm == ntms_pkg::ST_FOLLOW);
  c_zone_change: cover property (st_r.load_tz);
  c_answer: cover property (st_r.resp_pend ##1 $rose(tx_valid));
endmodule

// ### core/ntms_pkg.sv
/*
  Holds the shared constants and types of the network time master block: timing figures,
  payload byte layout, calendar limits, group numbers of the time messages and the state
  encoding of the master arbitration. Assumes a single 250 MHz clock domain.
*/
package ntms_pkg;
  // Clock rate and the one-second tick derived from it.
  localparam int CLK_HZ = 32'h0ee6_b280;
  localparam int TICK_S = 32'h0000_0001;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int MS_PER_S = 32'h0000_03e8;
  // Hold-off after joining, silence before resuming, and the broadcast period.
  localparam int HOLD_S = 32'h0000_0003;
  localparam int SILENCE_S = 32'h0000_0003;
  localparam int PERIOD_MS = 32'h0000_03e8;
  localparam logic [1:0] HOLD_TICKS = 2'(HOLD_S / TICK_S);
  localparam logic [1:0] SILENCE_TICKS = 2'(SILENCE_S / TICK_S);
  localparam logic [1:0] PERIOD_TICKS = 2'(PERIOD_MS / (TICK_S * MS_PER_S));
  // Group numbers of the status broadcast and of the set command.
  localparam logic [16:0] GRP_STATUS = 17'h1_ffff;
  localparam logic [16:0] GRP_SET = 17'h1_fffe;
  // Fill value that marks an unused byte of a set command.
  localparam logic [7:0] FILL_BYTE = 8'hff;
  // Payload byte positions (byte k occupies bits 8k+7 down to 8k).
  localparam int BYTE_HOUR = 32'h0000_0004;
  localparam int BYTE_ZONE = 32'h0000_0007;
  localparam int PAYLOAD_BYTES = 32'h0000_0008;
  // Calendar limits and reset values.
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] DOW_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h0c;
  localparam logic [7:0] YEAR_MAX = 8'hfa;
  localparam logic [7:0] FIRST_ONE = 8'h01;
  localparam logic [7:0] FEBRUARY = 8'h02;
  localparam logic [7:0] DAYS_28 = 8'h1c;
  localparam logic [7:0] DAYS_29 = 8'h1d;
  localparam logic [7:0] DAYS_30 = 8'h1e;
  localparam logic [7:0] DAYS_31 = 8'h1f;
  localparam logic [7:0] CENTURY_1 = 8'h64;
  localparam logic [7:0] CENTURY_2 = 8'hc8;
  // Payload fields; the first field sits in the top byte, so year is byte zero.
  typedef struct packed {
    logic [7:0] zone;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dow;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } ntms_time_t;
  // Master arbitration states, Gray coded along hold, master, follow.
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_MASTER = 2'b01,
    ST_FOLLOW = 2'b11
  } ntms_state_t;
endpackage

// ### core/ntms_tick.sv
/*
  Holds the one-second tick divider of the network time master block.
  Assumes a free running clock; the period is a parameter so simulation can shorten it.
*/
`timescale 1ns/1ps
module ntms_tick #(
  parameter logic [27:0] TICK_CYCLES = 28'(ntms_pkg::TICK_CYCLES)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // One-cycle pulse once per second
  output logic tick
);
  typedef struct packed {
    logic [27:0] cnt;
    logic tick;
  } ntms_tick_t;
  ntms_tick_t st_r;
  ntms_tick_t st_nxt;

  // Counts clock cycles and pulses the tick in the cycle after the last one of each second.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == TICK_CYCLES - 28'h000_0001) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 28'h000_0001;
    end
  end

  // Registers the divider state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// ### core/ntms_cal.sv
/*
  Holds the local calendar of the network time master block: it advances once per tick
  and is loaded whole or in hour and zone only. Assumes single-cycle load pulses.
*/
`timescale 1ns/1ps
module ntms_cal (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Advance and load controls
  input wire logic tick,
  input wire logic load_all,
  input wire logic load_tz,
  input wire logic [63:0] load_data,
  // Current time in payload layout
  output logic [63:0] now
);
  ntms_pkg::ntms_time_t st_r;
  ntms_pkg::ntms_time_t st_nxt;
  ntms_pkg::ntms_time_t ld;

  // Returns the length of a month, with the century years that are not leap years.
  function automatic logic [7:0] days_in(input logic [7:0] yr, input logic [7:0] mo);
    if (mo == ntms_pkg::FEBRUARY) begin
      days_in = (yr[1:0] == 2'b00 && yr != ntms_pkg::CENTURY_1 && yr != ntms_pkg::CENTURY_2)
                ? ntms_pkg::DAYS_29 : ntms_pkg::DAYS_28;
    end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h0b) begin
      days_in = ntms_pkg::DAYS_30;
    end else begin
      days_in = ntms_pkg::DAYS_31;
    end
  endfunction

  // Loads win over the tick; otherwise each tick carries seconds upward.
  always_comb begin
    ld = ntms_pkg::ntms_time_t'(load_data);
    st_nxt = st_r;
    if (load_all) begin
      st_nxt = ld;
    end else if (load_tz) begin
      st_nxt.hour = ld.hour;
      st_nxt.zone = ld.zone;
    end else if (tick) begin
      st_nxt.sec = st_r.sec + ntms_pkg::FIRST_ONE;
      if (st_r.sec >= ntms_pkg::SEC_MAX) begin
        st_nxt.sec = '0;
        st_nxt.min = st_r.min + ntms_pkg::FIRST_ONE;
        if (st_r.min >= ntms_pkg::MIN_MAX) begin
          st_nxt.min = '0;
          st_nxt.hour = st_r.hour + ntms_pkg::FIRST_ONE;
          if (st_r.hour >= ntms_pkg::HOUR_MAX) begin
            st_nxt.hour = '0;
            st_nxt.dow = (st_r.dow >= ntms_pkg::DOW_MAX) ? ntms_pkg::FIRST_ONE
                         : st_r.dow + ntms_pkg::FIRST_ONE;
            st_nxt.date = st_r.date + ntms_pkg::FIRST_ONE;
            if (st_r.date >= days_in(st_r.year, st_r.month)) begin
              st_nxt.date = ntms_pkg::FIRST_ONE;
              st_nxt.month = st_r.month + ntms_pkg::FIRST_ONE;
              if (st_r.month >= ntms_pkg::MONTH_MAX) begin
                st_nxt.month = ntms_pkg::FIRST_ONE;
                if (st_r.year < ntms_pkg::YEAR_MAX) begin
                  st_nxt.year = st_r.year + ntms_pkg::FIRST_ONE;
                end
              end
            end
          end
        end
      end
    end
  end

  // Registers the calendar; reset gives the first day of the base year.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{zone: 8'h00, sec: 8'h00, min: 8'h00, hour: 8'h00, dow: 8'h01, date: 8'h01,
                month: 8'h01, year: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign now = st_r;

  // A full load shows up one edge later and is not overtaken by a tick.
  a_load_wins: assert property (@(posedge clk) disable iff (!rstn)
    load_all |=> now == $past(load_data)) else $error("calendar did not take full load");
  // The seconds field stays within its range.
  a_sec_range: assert property (@(posedge clk) disable iff (!rstn)
    !$past(load_all) |-> st_r.sec <= ntms_pkg::SEC_MAX) else $error("seconds out of range");
endmodule

// ### tb/ntms_peer.sv
/*
  Holds a model of the frame engine that takes status frames from the time master.
  Assumes the bench shares clk and rstn and drives stall to hold frames back.
*/
`timescale 1ns/1ps
module ntms_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Offered frame and stall control
  input wire logic tx_valid,
  input wire logic [63:0] tx_data,
  input wire logic stall,
  output logic tx_ready,
  // Record of taken frames
  output int taken,
  output int gap,
  output logic [63:0] last
);
  int cyc; // Cycles since reset.
  int pcyc; // Cycle of the previous take.
  // Ready drops while stalled, so the master must hold its frame.
  assign tx_ready = !stall;
  // Retires a frame on valid and ready and notes the spacing between frames.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc <= 0;
      pcyc <= 0;
      taken <= 0;
      gap <= 0;
      last <= '0;
    end else begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready) begin
        taken <= taken + 1;
        gap <= cyc - pcyc;
        pcyc <= cyc;
        last <= tx_data;
      end
    end
  end
endmodule

// ### tb/testbench.sv
/*
  Holds the self-checking bench of the time master: hold-off, period, stall, set
  commands, zone change, calendar carry, following and resuming.
  Assumes a shortened second of TK cycles and a frame engine model on the transmit side.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  localparam int TK = 20; // Cycles per shortened second.
  logic clk = 0, rstn = 0, rx_valid = 0, stall = 0, ack_s;
  logic [16:0] grp = '0;
  logic [7:0] src = '0, own = 8'h80, ack_d, ack_dest;
  logic [63:0] rxd = '0, d, tx_data, time_now, last, tn_s;
  logic tx_valid, tx_ready, ack_valid, is_master;
  logic [31:0] seed = 32'h1777_19ed;
  int failures = 0, checks = 0, cyc = 0, taken, gap, n;
  ntms_master #(.TICK_CYCLES(28'(TK))) u_dut (.clk(clk), .rstn(rstn), .own_addr(own),
    .rx_valid(rx_valid), .rx_data_group_number(grp), .rx_src(src), .rx_data(rxd),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .ack_valid(ack_valid),
    .ack_dest(ack_dest), .is_master(is_master), .time_now(time_now));
  ntms_peer u_peer (.clk(clk), .rstn(rstn), .tx_valid(tx_valid), .tx_data(tx_data),
    .stall(stall), .tx_ready(tx_ready), .taken(taken), .gap(gap), .last(last));
  always #2 clk = ~clk;
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Packs a payload with byte zero lowest.
  function automatic logic [63:0] mk(input logic [7:0] y, mo, dt, w, h, mi, s, z);
    return {z, s, mi, h, w, dt, mo, y};
  endfunction
  // Draws a legal time; seconds stay below 59 to avoid a carry.
  function automatic logic [63:0] rtime();
    return mk(8'(rnd() % 251), 8'(1 + rnd() % 12), 8'(1 + rnd() % 28), 8'(1 + rnd() % 7),
      8'(rnd() % 24), 8'(rnd() % 60), 8'(rnd() % 59), 8'(rnd() % 24));
  endfunction
  // Presents one frame, samples the acknowledge pulse while it stands one edge later and
  // the loaded time two edges later, before a tick can move it; returns three edges later.
  task send(input logic [16:0] g, input logic [7:0] s, input logic [63:0] v);
    @(posedge clk); #1; rx_valid = 1; grp = g; src = s; rxd = v;
    @(posedge clk); #1; rx_valid = 0; rxd = ~v; ack_s = ack_valid; ack_d = ack_dest;
    @(posedge clk); #1; tn_s = time_now;
    @(posedge clk); #1;
  endtask
  task wait_tx(input int lim);
    n = 0;
    while (tx_valid !== 1'b1 && n < lim) begin
      @(posedge clk); #1; n++;
    end
  endtask
  task print_verdict();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    #1; rstn = 1;
    `CHK(time_now, mk(0, 1, 1, 1, 0, 0, 0, 0))
    `CHK(is_master, 1'b0)
    wait_tx(4 * TK);
    `CHK(n >= 3 * TK - 3 && n <= 3 * TK + 2, 1'b1)
    // The frame carries the calendar as it stood before the third tick was counted.
    `CHK(tx_data, mk(0, 1, 1, 1, 0, 0, 2, 0))
    `CHK(is_master, 1'b1)
    repeat (2 * TK + 2) @(posedge clk);
    #1;
    `CHK(taken, 3)
    `CHK(gap, TK)
    // The frame must stand unchanged while the engine stalls.
    stall = 1;
    wait_tx(2 * TK);
    d = tx_data;
    repeat (2 * TK) @(posedge clk);
    #1;
    `CHK(tx_valid, 1'b1)
    `CHK(tx_data, d)
    stall = 0;
    n = taken;
    @(posedge clk); #1;
    `CHK(taken, n + 1)
    // Random set commands from lower addresses while master.
    repeat (6) begin
      d = rtime();
      n = taken;
      // These act as user settings; a reference node would send only beyond 2 s.
      send(ntms_pkg::GRP_SET, 8'(rnd() % 128), d);
      `CHK(tn_s, d)
      `CHK(ack_s, 1'b1)
      `CHK(ack_d, src)
      repeat (2) @(posedge clk);
      #1;
      `CHK(taken > n, 1'b1)
    end
    d = rtime();
    send(ntms_pkg::GRP_STATUS, own, d);
    `CHK(time_now == d, 1'b0)
    d = time_now;
    send(ntms_pkg::GRP_SET, 8'h11, {8'h05, 16'hffff, 8'h09, 32'hffff_ffff});
    `CHK(time_now[31:0], d[31:0])
    `CHK({time_now[63:56], time_now[39:32]}, 16'h0509)
    send(ntms_pkg::GRP_SET, 8'h11, mk(5, 12, 31, 7, 23, 59, 59, 3));
    n = 0;
    while (time_now[55:48] === 8'h3b && n < 2 * TK) begin
      @(posedge clk); #1; n++;
    end
    `CHK(time_now, mk(6, 1, 1, 1, 0, 0, 0, 3))
    // A higher address takes over; this node follows and stays quiet.
    d = rtime();
    send(ntms_pkg::GRP_STATUS, 8'hc0, d);
    `CHK(tn_s, d)
    `CHK(is_master, 1'b0)
    send(ntms_pkg::GRP_SET, 8'h22, rtime());
    `CHK(ack_s, 1'b1)
    repeat (3) @(posedge clk);
    #1;
    `CHK(tx_valid, 1'b0)
    // Statuses come closer than the silence limit, so at most two ticks pass between them.
    repeat (3) begin
      repeat (TK) @(posedge clk);
      send(ntms_pkg::GRP_STATUS, 8'hc0, rtime());
    end
    `CHK(is_master, 1'b0)
    wait_tx(5 * TK);
    `CHK(n >= 2 * TK && n < 5 * TK, 1'b1)
    `CHK(is_master, 1'b1)
    print_verdict();
  end
endmodule
